// File: logic/spl_regs.vh
// Register offsets, field layouts and reset values of the sixteen point linearizer
`ifndef SPL_REGS_VH
`define SPL_REGS_VH
// ***********************
// Register byte offsets
// ***********************
`define SPL_CTRL_OFS      8'h00
`define SPL_POINTS_OFS    8'h04
`define SPL_UPPER_OFS     8'h08
`define SPL_LOWER_OFS     8'h0c
`define SPL_FB_VALUE_OFS  8'h10
`define SPL_INPUT_OFS     8'h14
`define SPL_OUTPUT_OFS    8'h18
`define SPL_STATUS_OFS    8'h1c
`define SPL_IRQ_STAT_OFS  8'h20
`define SPL_IRQ_MASK_OFS  8'h24
`define SPL_TABLE_OFS     8'h40
`define SPL_TABLE_END     8'hc0
// ***********************
// Fields and codes
// ***********************
`define SPL_CTRL_CFG_BIT  0
`define SPL_CTRL_INBAD_BIT 1
`define SPL_FB_DOWNSCALE  2'h0
`define SPL_FB_UPSCALE    2'h1
`define SPL_FB_VALUE      2'h2
`define SPL_FB_HOLD       2'h3
`define SPL_SHAPE_INC     3'h0
`define SPL_SHAPE_DEC     3'h1
`define SPL_SHAPE_FREE    3'h2
`define SPL_SHAPE_SKIP    3'h3
`define SPL_SHAPE_NONE    3'h4
`define SPL_IRQ_CFG_BIT   0
`define SPL_IRQ_FB_BIT    1
`define SPL_IRQ_SHAPE_BIT 2
// ***********************
// Reset values
// ***********************
`define SPL_POINTS_RST    5'h10
`define SPL_UPPER_RST     16'h7fff
`define SPL_LOWER_RST     16'h8000
`endif

// File: logic/spl_linearizer.v
// Sixteen point piecewise linear converter with an AHB-Lite register slave
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
// Operation
// - Table holds up to sixteen breakpoint and output value pairs.
// - Output interpolates linearly between consecutive valid points.
// - Only the first active_point_count points are used.
// - End segments extend straight beyond the outermost used points.
// - Points breaking strictly increasing inputs are excluded.
// - Any excluded point reports the skipped points shape if two or more points remain kept.
// - No valid interval reports no valid shape and applies fallback.
// - Bad input status applies fallback.
// - Output below lower or above upper limit applies fallback.
// - Otherwise shape is increasing, decreasing or free by output trend.
// - Fallback type, value, units, resolution change only in configuration mode.
// - Any configuration change raises an integral balance request pulse.
`include "spl_regs.vh"
module spl_linearizer #(
  parameter NPTS = 16,
  parameter DW   = 16
) (
  // Clock and reset
  input  wire          hclk,
  input  wire          hresetn,
  // AHB-Lite slave
  input  wire          hsel,
  input  wire [7:0]    haddr,
  input  wire [1:0]    htrans,
  input  wire          hwrite,
  input  wire [2:0]    hsize,
  input  wire          hready,
  input  wire [31:0]   hwdata,
  output wire [31:0]   hrdata,
  output wire          hreadyout,
  output wire          hresp,
  // Conversion outputs
  output reg  [DW-1:0] lin_output,
  output reg           output_bad,
  output reg           integral_balance_request,
  output wire          irq
);

  // ***********************
  // Register storage
  // ***********************
  reg  [DW-1:0] first_input_breakpoint [0:NPTS-1];
  reg  [DW-1:0] first_output_value     [0:NPTS-1];
  reg           cfg_mode;
  reg           input_bad;
  reg  [4:0]    active_point_count;
  reg  [DW-1:0] output_upper_limit;
  reg  [DW-1:0] output_lower_limit;
  reg  [DW-1:0] fb_value;
  reg  [1:0]    fb_type;
  reg  [3:0]    out_units;
  reg  [3:0]    out_res;
  reg  [DW-1:0] lin_input;
  reg  [2:0]    curve_shape_status;
  reg  [2:0]    irq_stat;
  reg  [2:0]    irq_mask;
  reg  [31:0]   rdata;
  // Address phase capture
  reg           wr_pend;
  reg  [7:0]    wr_addr;
  reg           cfg_change;
  wire          addr_ok = hsel & hready & htrans[1];
  // One loop index per process, so no process wakes another
  integer       i;
  integer       j;
  integer       m;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata;
  assign irq       = |(irq_stat & irq_mask);

  // ***********************
  // Point validity and curve scan
  // ***********************
  // Each point is kept only if its input exceeds the last kept one.
  reg  [NPTS-1:0] kept;
  reg  [DW-1:0]   last_in;
  reg             have_last;
  reg             any_skip;
  reg  [4:0]      n_kept;
  reg             rise;
  reg             fall;
  reg  [DW-1:0]   last_out;
  always @* begin
    kept      = {NPTS{1'b0}};
    last_in   = {DW{1'b0}};
    last_out  = {DW{1'b0}};
    have_last = 1'b0;
    any_skip  = 1'b0;
    n_kept    = 5'h00;
    rise      = 1'b0;
    fall      = 1'b0;
    for (j = 0; j < NPTS; j = j + 1) begin
      if (j < active_point_count) begin
        if (!have_last || $signed(first_input_breakpoint[j]) > $signed(last_in)) begin
          kept[j] = 1'b1;
          if (have_last && $signed(first_output_value[j]) > $signed(last_out))
            rise = 1'b1;
          if (have_last && $signed(first_output_value[j]) < $signed(last_out))
            fall = 1'b1;
          last_in   = first_input_breakpoint[j];
          last_out  = first_output_value[j];
          have_last = 1'b1;
          n_kept    = n_kept + 5'h01;
        end else begin
          any_skip = 1'b1;
        end
      end
    end
  end

  // ***********************
  // Segment selection
  // ***********************
  // Picks the kept pair around the input; the first or last pair when outside.
  reg  [DW-1:0] x0;
  reg  [DW-1:0] y0;
  reg  [DW-1:0] x1;
  reg  [DW-1:0] y1;
  reg           seg_done;
  reg           prev_ok;
  reg  [DW-1:0] px;
  reg  [DW-1:0] py;
  always @* begin
    x0 = {DW{1'b0}};
    y0 = {DW{1'b0}};
    x1 = {DW{1'b0}};
    y1 = {DW{1'b0}};
    px = {DW{1'b0}};
    py = {DW{1'b0}};
    seg_done = 1'b0;
    prev_ok  = 1'b0;
    for (m = 0; m < NPTS; m = m + 1) begin
      if (kept[m] && !seg_done) begin
        if (prev_ok) begin
          x0 = px;
          y0 = py;
          x1 = first_input_breakpoint[m];
          y1 = first_output_value[m];
          if ($signed(lin_input) <= $signed(first_input_breakpoint[m]))
            seg_done = 1'b1;
        end
        px = first_input_breakpoint[m];
        py = first_output_value[m];
        prev_ok = 1'b1;
      end
    end
  end

  // ***********************
  // Interpolation
  // ***********************
  // Division is combinational; a single pass keeps latency at one cycle
  // at the cost of a long path.
  wire signed [DW+1:0]   dx  = $signed({x1[DW-1], x1[DW-1], x1}) - $signed({x0[DW-1], x0[DW-1], x0});
  wire signed [DW+1:0]   dy  = $signed({y1[DW-1], y1[DW-1], y1}) - $signed({y0[DW-1], y0[DW-1], y0});
  wire signed [DW+1:0]   du  = $signed({lin_input[DW-1], lin_input[DW-1], lin_input})
                               - $signed({x0[DW-1], x0[DW-1], x0});
  wire signed [2*DW+3:0] num = du * dy;
  // Both arms signed, else the divide would be done unsigned
  wire signed [2*DW+3:0] qt  = (dx == 0) ? $signed({(2*DW+4){1'b0}}) : num / dx;
  wire signed [2*DW+3:0] calc = qt + {{(DW+4){y0[DW-1]}}, y0};
  wire                   no_form = (n_kept < 5'h02);
  wire signed [2*DW+3:0] up_w = {{(DW+4){output_upper_limit[DW-1]}}, output_upper_limit};
  wire signed [2*DW+3:0] lo_w = {{(DW+4){output_lower_limit[DW-1]}}, output_lower_limit};
  wire                   over_range = (calc > up_w) | (calc < lo_w);
  wire                   use_fb = no_form | input_bad | over_range;

  reg  [2:0]    next_shape;
  always @* begin
    if (no_form)
      next_shape = `SPL_SHAPE_NONE;
    else if (any_skip)
      next_shape = `SPL_SHAPE_SKIP;
    else if (rise && fall)
      next_shape = `SPL_SHAPE_FREE;
    else if (fall)
      next_shape = `SPL_SHAPE_DEC;
    else
      next_shape = `SPL_SHAPE_INC;
  end

  reg  [DW-1:0] next_output;
  always @* begin
    case (fb_type)
      `SPL_FB_DOWNSCALE: next_output = output_lower_limit;
      `SPL_FB_UPSCALE:   next_output = output_upper_limit;
      `SPL_FB_VALUE:     next_output = fb_value;
      `SPL_FB_HOLD:      next_output = lin_output;
      default:           next_output = fb_value;
    endcase
    if (!use_fb)
      next_output = calc[DW-1:0];
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lin_output               <= {DW{1'b0}};
      output_bad               <= 1'b1;
      curve_shape_status       <= `SPL_SHAPE_NONE;
      integral_balance_request <= 1'b0;
    end else begin
      lin_output               <= next_output;
      output_bad               <= use_fb;
      curve_shape_status       <= next_shape;
      integral_balance_request <= cfg_change;
    end
  end

  // ***********************
  // Bus slave, zero wait state
  // ***********************
  // A write lands at the end of its data phase; status and output follow one
  // cycle later, so software reads them back after a spare cycle.
  wire          wr_now   = wr_pend;
  wire          tbl_hit  = (wr_addr >= `SPL_TABLE_OFS) && (wr_addr < `SPL_TABLE_END);
  // Entry k sits 8*k above the table base, which lies on a 64-byte boundary
  wire [3:0]    tbl_idx  = {~wr_addr[6], wr_addr[5:3]};
  wire          rd_tbl   = (haddr >= `SPL_TABLE_OFS) && (haddr < `SPL_TABLE_END);
  wire [3:0]    rd_idx   = {~haddr[6], haddr[5:3]};
  wire [DW-1:0] rd_entry = haddr[2] ? first_output_value[rd_idx]
                                    : first_input_breakpoint[rd_idx];

  always @* begin
    cfg_change = 1'b0;
    if (wr_now) begin
      case (wr_addr)
        `SPL_CTRL_OFS, `SPL_POINTS_OFS, `SPL_UPPER_OFS,
        `SPL_LOWER_OFS, `SPL_FB_VALUE_OFS: cfg_change = 1'b1;
        default: cfg_change = tbl_hit;
      endcase
    end
  end

  // ***********************
  // Interrupt events
  // ***********************
  // Shape change is judged against a held copy, so it is flagged one cycle late
  reg  [2:0]    shape_q;
  wire [2:0]    ev_set;
  wire [2:0]    ev_clr;
  assign ev_set[`SPL_IRQ_CFG_BIT]   = cfg_change;
  assign ev_set[`SPL_IRQ_FB_BIT]    = use_fb & ~output_bad;
  assign ev_set[`SPL_IRQ_SHAPE_BIT] = (curve_shape_status != shape_q);
  assign ev_clr = (wr_now && wr_addr == `SPL_IRQ_STAT_OFS) ? hwdata[2:0] : 3'h0;

  // Set wins over a same-cycle write-one clear, so no event is lost
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= 3'h0;
      shape_q  <= `SPL_SHAPE_NONE;
    end else begin
      irq_stat <= (irq_stat & ~ev_clr) | ev_set;
      shape_q  <= curve_shape_status;
    end
  end

  // ***********************
  // Read data
  // ***********************
  // Captured in the address phase and held until the next read is taken
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      case (haddr)
        `SPL_CTRL_OFS:     rdata <= {30'h0, input_bad, cfg_mode};
        `SPL_POINTS_OFS:   rdata <= {17'h0, out_res, out_units, fb_type, active_point_count};
        `SPL_UPPER_OFS:    rdata <= {16'h0, output_upper_limit};
        `SPL_LOWER_OFS:    rdata <= {16'h0, output_lower_limit};
        `SPL_FB_VALUE_OFS: rdata <= {16'h0, fb_value};
        `SPL_INPUT_OFS:    rdata <= {16'h0, lin_input};
        `SPL_OUTPUT_OFS:   rdata <= {16'h0, lin_output};
        `SPL_STATUS_OFS:   rdata <= {27'h0, output_bad, 1'b0, curve_shape_status};
        `SPL_IRQ_STAT_OFS: rdata <= {29'h0, irq_stat};
        `SPL_IRQ_MASK_OFS: rdata <= {29'h0, irq_mask};
        default:           rdata <= rd_tbl ? {16'h0, rd_entry} : 32'h0000_0000;
      endcase
    end
  end

  // ***********************
  // Register writes
  // ***********************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend            <= 1'b0;
      wr_addr            <= 8'h00;
      cfg_mode           <= 1'b0;
      input_bad          <= 1'b0;
      active_point_count <= `SPL_POINTS_RST;
      output_upper_limit <= `SPL_UPPER_RST;
      output_lower_limit <= `SPL_LOWER_RST;
      fb_value           <= {DW{1'b0}};
      fb_type            <= `SPL_FB_DOWNSCALE;
      out_units          <= 4'h0;
      out_res            <= 4'h0;
      lin_input          <= {DW{1'b0}};
      irq_mask           <= 3'h0;
      for (i = 0; i < NPTS; i = i + 1) begin
        first_input_breakpoint[i] <= {DW{1'b0}};
        first_output_value[i]     <= {DW{1'b0}};
      end
    end else begin
      wr_pend <= addr_ok & hwrite;
      if (addr_ok)
        wr_addr <= haddr;
      if (wr_now) begin
        case (wr_addr)
          `SPL_CTRL_OFS: begin
            cfg_mode  <= hwdata[`SPL_CTRL_CFG_BIT];
            input_bad <= hwdata[`SPL_CTRL_INBAD_BIT];
          end
          `SPL_POINTS_OFS: begin
            active_point_count <= (hwdata[4:0] > 5'h10) ? 5'h10 : hwdata[4:0];
            if (cfg_mode) begin
              fb_type   <= hwdata[6:5];
              out_units <= hwdata[10:7];
              out_res   <= hwdata[14:11];
            end
          end
          `SPL_UPPER_OFS:    output_upper_limit <= hwdata[DW-1:0];
          `SPL_LOWER_OFS:    output_lower_limit <= hwdata[DW-1:0];
          `SPL_FB_VALUE_OFS: if (cfg_mode) fb_value <= hwdata[DW-1:0];
          `SPL_INPUT_OFS:    lin_input <= hwdata[DW-1:0];
          `SPL_IRQ_MASK_OFS: irq_mask <= hwdata[2:0];
          default: begin
            if (tbl_hit && wr_addr[2])
              first_output_value[tbl_idx] <= hwdata[DW-1:0];
            else if (tbl_hit)
              first_input_breakpoint[tbl_idx] <= hwdata[DW-1:0];
          end
        endcase
      end
    end
  end

endmodule // spl_linearizer

// File: bench/spl_monitor.sv
// Port assertions of the sixteen point linearizer
`timescale 1ns/100ps
module spl_monitor #(
  parameter DW = 16
) (
  // Clock and reset
  input wire          hclk,
  input wire          hresetn,
  // Bus inputs
  input wire          hsel,
  input wire [7:0]    haddr,
  input wire [1:0]    htrans,
  input wire          hwrite,
  input wire          hready,
  input wire [31:0]   hwdata,
  // Conversion outputs
  input wire [DW-1:0] lin_output,
  input wire          output_bad,
  input wire          integral_balance_request
);
  // Shadow of the limits and fallback settings, kept from bus writes
  reg          aw, live;
  reg [7:0]    aa;
  reg [1:0]    fb, ctl;
  reg [DW-1:0] up, lo, fv;
  wire         tw = hsel && hready && htrans[1] && hwrite;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aw <= 1'b0;
      live <= 1'b0;
      aa <= 8'h00;
      fb <= 2'h0;
      ctl <= 2'h0;
      up <= 16'h7fff;
      lo <= 16'h8000;
      fv <= 16'h0000;
    end else begin
      aw <= tw;
      aa <= haddr;
      live <= 1'b1;
      if (aw && aa == 8'h00) ctl <= hwdata[1:0];
      if (aw && aa == 8'h04 && ctl[0]) fb <= hwdata[6:5];
      if (aw && aa == 8'h08) up <= hwdata[DW-1:0];
      if (aw && aa == 8'h0c) lo <= hwdata[DW-1:0];
      if (aw && aa == 8'h10 && ctl[0]) fv <= hwdata[DW-1:0];
    end
  end
  // Outputs lag the registers by one cycle, hence the past values
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_ibr_after_write: assert property (
    tw && haddr >= 8'h40 && haddr < 8'hc0 |-> ##2 integral_balance_request)
    else $error("no balance request");
  chk_ibr_has_cause: assert property (
    $rose(integral_balance_request) |-> $past(tw, 2))
    else $error("balance request without write");
  chk_bad_input: assert property (
    live && $past(ctl[1]) |-> output_bad)
    else $error("bad input ignored");
  chk_inside_limits: assert property (
    live && !output_bad |-> $signed(lin_output) >= $signed($past(lo))
      && $signed(lin_output) <= $signed($past(up)))
    else $error("good output outside limits");
  chk_fb_down: assert property (
    live && output_bad && $past(fb) == 2'h0 |-> lin_output == $past(lo))
    else $error("downscale output wrong");
  chk_fb_up: assert property (
    live && output_bad && $past(fb) == 2'h1 |-> lin_output == $past(up))
    else $error("upscale output wrong");
  chk_fb_value: assert property (
    live && output_bad && $past(fb) == 2'h2 |-> lin_output == $past(fv))
    else $error("fallback value wrong");
  chk_fb_hold: assert property (
    output_bad && $past(output_bad) && $past(fb) == 2'h3 && $past(fb, 2) == 2'h3
      |-> $stable(lin_output))
    else $error("held output moved");
endmodule // spl_monitor

bind spl_linearizer spl_monitor #(.DW(DW)) u_monitor (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .lin_output(lin_output),
  .output_bad(output_bad), .integral_balance_request(integral_balance_request));

// File: bench/spl_loop_model.sv
// Control loop model that counts integral balance requests
`timescale 1ns/100ps
module spl_loop_model (
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // Converter output
  input  wire       integral_balance_request,
  // Observation
  output reg  [7:0] kick_count
);
  // Each request adds one to kick_count
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      kick_count <= 8'h00;
    else if (integral_balance_request)
      kick_count <= kick_count + 8'h01;
  end
endmodule // spl_loop_model

// File: bench/spl_linearizer_bench.sv
// Self-checking bench of the linearizer through its registers
`timescale 1ns/100ps
module spl_linearizer_bench;
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         hsel = 1'b0;
  reg  [7:0]  haddr = 8'h00;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg  [31:0] rd;
  reg  [7:0]  snap;
  wire [31:0] hrdata;
  wire [15:0] lin_output;
  wire [7:0]  kick_count;
  wire        hreadyout, output_bad, integral_balance_request, irq;
  integer     n_errors = 0, n_compared = 0, cyc = 0;
  always #2.5 hclk = ~hclk;
  spl_linearizer dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .lin_output(lin_output), .output_bad(output_bad),
    .integral_balance_request(integral_balance_request), .irq(irq));
  spl_loop_model u_loop (
    .hclk(hclk), .hresetn(hresetn), .kick_count(kick_count),
    .integral_balance_request(integral_balance_request));
  task chk(input [63:0] nm, input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // Entered just after a rising edge; one slave, so hreadyout is hready
  task xfer(input w, input [7:0] a, input [15:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {16'h0000, d};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdc(input [63:0] nm, input [7:0] a, input [15:0] e);
    begin
      // Status follows a write one cycle after it lands
      @(posedge hclk);
      xfer(1'b0, a, 16'h0000);
      chk(nm, rd[15:0], e);
    end
  endtask
  task pt(input [3:0] k, input [15:0] x, input [15:0] y);
    begin
      wr({1'b0, k, 3'h0} + 8'h40, x);
      wr({1'b0, k, 3'h4} + 8'h40, y);
    end
  endtask
  task cv(input [15:0] x, input [15:0] y, input b);
    begin
      wr(8'h14, x);
      repeat (2) @(posedge hclk);
      chk("output", lin_output, y);
      chk("bad", {15'h0000, output_bad}, {15'h0000, b});
    end
  endtask
  task give_verdict;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_errors = n_errors + 1;
      give_verdict;
    end
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("upper", 8'h08, 16'h7fff);
    rdc("status", 8'h1c, 16'h0014);
    rdc("unmapped", 8'hc4, 16'h0000);
    cv(16'h0032, 16'h8000, 1'b1);
    $display("test reset done");
    pt(4'h1, 16'h0064, 16'h03e8);
    pt(4'h2, 16'h00c8, 16'h0bb8);
    wr(8'h04, 16'h0003);
    cv(16'h0032, 16'h01f4, 1'b0);
    cv(16'h0096, 16'h07d0, 1'b0);
    cv(16'h00fa, 16'h0fa0, 1'b0);
    cv(16'hffce, 16'hfe0c, 1'b0);
    rdc("status", 8'h1c, 16'h0000);
    wr(8'h08, 16'h0bb8);
    cv(16'h00fa, 16'h8000, 1'b1);
    wr(8'h08, 16'h7fff);
    wr(8'h04, 16'h0004);
    rdc("status", 8'h1c, 16'h0003);
    cv(16'h0096, 16'h07d0, 1'b0);
    $display("test increasing done");
    wr(8'h04, 16'h0003);
    wr(8'h44, 16'h0bb8);
    wr(8'h54, 16'h0000);
    rdc("status", 8'h1c, 16'h0001);
    cv(16'h0096, 16'h01f4, 1'b0);
    wr(8'h44, 16'h0000);
    wr(8'h54, 16'h01f4);
    rdc("status", 8'h1c, 16'h0002);
    wr(8'h04, 16'h0001);
    rdc("status", 8'h1c, 16'h0014);
    wr(8'h04, 16'h0003);
    $display("test shapes done");
    wr(8'h0c, 16'hf060);
    wr(8'h08, 16'h1770);
    wr(8'h00, 16'h0001);
    wr(8'h10, 16'h0123);
    wr(8'h00, 16'h0002);
    wr(8'h10, 16'h0456);
    wr(8'h04, 16'h0043);
    cv(16'h0096, 16'hf060, 1'b1);
    wr(8'h00, 16'h0003);
    wr(8'h04, 16'h0043);
    cv(16'h0096, 16'h0123, 1'b1);
    wr(8'h04, 16'h0023);
    cv(16'h0096, 16'h1770, 1'b1);
    wr(8'h00, 16'h0001);
    cv(16'h0096, 16'h02ee, 1'b0);
    wr(8'h04, 16'h0063);
    wr(8'h00, 16'h0003);
    cv(16'h0096, 16'h02ee, 1'b1);
    $display("test fallback done");
    wr(8'h00, 16'h0000);
    wr(8'h04, 16'h0783);
    rdc("points", 8'h04, 16'h0063);
    wr(8'h24, 16'h0001);
    wr(8'h20, 16'h0007);
    repeat (2) @(posedge hclk);
    chk("irq", {15'h0000, irq}, 16'h0000);
    snap = kick_count;
    pt(4'h3, 16'h012c, 16'h0fa0);
    repeat (2) @(posedge hclk);
    chk("kicks", {8'h00, kick_count}, {8'h00, snap + 8'h02});
    chk("irq", {15'h0000, irq}, 16'h0001);
    wr(8'h24, 16'h0000);
    repeat (2) @(posedge hclk);
    chk("irq", {15'h0000, irq}, 16'h0000);
    $display("test events done");
    give_verdict;
  end
endmodule // spl_linearizer_bench
